//--- hw/apch_channel.sv
// apch_channel: host signalling of the primary ATA channel, command side to drive pins
// assumes one command at a time from the bus-master engine; link_clk drives the pin timing
`timescale 1ns/1ps
`default_nettype none
module apch_channel
  import apch_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 3
) (
  // system
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic power_on_suspend,
  input wire logic arrange_pm_ps,
  // command from the bus-master engine
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic cmd_ctl_block,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  // response
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic cfg_pm_ps,
  // drive pins
  input wire logic pri_dma_req,
  output logic pri_dma_ack_n,
  output logic pri_read_cmd_n,
  output logic pri_write_cmd_n,
  output logic pri_write_cmd_oe,
  input wire logic pri_channel_ready,
  output logic pri_cmd_block_sel_n,
  output logic pri_ctl_block_sel_n,
  output logic [ADDR_W-1:0] pri_reg_addr,
  input wire logic [DATA_W-1:0] pri_data_in,
  output logic [DATA_W-1:0] pri_data_out,
  output logic pri_data_oe
);

  function automatic logic is_write(input logic [2:0] op);
    return op[0];
  endfunction : is_write

  // only the bus-master command codes reach the request pair
  function automatic logic is_dma(input logic [2:0] op);
    return (op == OP_DMA_RD) || (op == OP_DMA_WR) || (op == OP_UD_RD) || (op == OP_UD_WR);
  endfunction : is_dma

  function automatic logic is_udma(input logic [2:0] op);
    return (op == OP_UD_RD) || (op == OP_UD_WR);
  endfunction : is_udma

  // command side, clk domain
  logic busy, next_busy;
  logic req_tgl, next_req_tgl;
  logic [2:0] pay_op, next_pay_op;
  logic pay_ctl, next_pay_ctl;
  logic [ADDR_W-1:0] pay_addr, next_pay_addr;
  logic [DATA_W-1:0] pay_wdata, next_pay_wdata;
  logic dn_seen, next_dn_seen;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic dn_s1, dn_s2, arr_s1, arr_s2;
  logic done_tgl;
  logic [DATA_W-1:0] result_data;

  assign cmd_ready = !busy;

  always_comb
  begin
    next_busy = busy;
    next_req_tgl = req_tgl;
    next_pay_op = pay_op;
    next_pay_ctl = pay_ctl;
    next_pay_addr = pay_addr;
    next_pay_wdata = pay_wdata;
    next_dn_seen = dn_seen;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    if (cmd_valid && !busy)
    begin
      next_busy = 1'b1;
      next_req_tgl = !req_tgl;
      next_pay_op = cmd_op;
      next_pay_ctl = cmd_ctl_block;
      next_pay_addr = cmd_addr;
      next_pay_wdata = cmd_wdata;
    end
    if (dn_s2 != dn_seen)
    begin
      next_dn_seen = dn_s2;
      next_busy = 1'b0;
      next_rsp_valid = 1'b1;
      next_rsp_rdata = result_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy <= 1'b0;
      req_tgl <= 1'b0;
      pay_op <= OP_REG_RD;
      pay_ctl <= 1'b0;
      pay_addr <= '0;
      pay_wdata <= '0;
      dn_seen <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      dn_s1 <= 1'b0;
      dn_s2 <= 1'b0;
      arr_s1 <= 1'b0;
      arr_s2 <= 1'b0;
      cfg_pm_ps <= 1'b0;
    end
    else
    begin
      busy <= next_busy;
      req_tgl <= next_req_tgl;
      pay_op <= next_pay_op;
      pay_ctl <= next_pay_ctl;
      pay_addr <= next_pay_addr;
      pay_wdata <= next_pay_wdata;
      dn_seen <= next_dn_seen;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      dn_s1 <= done_tgl;
      dn_s2 <= dn_s1;
      arr_s1 <= arrange_pm_ps;
      arr_s2 <= arr_s1;
      cfg_pm_ps <= arr_s2;
    end
  end

  // pin side, link_clk domain
  apch_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [2:0] op, next_op;
  logic req_s1, req_s2, req_seen, next_req_seen;
  logic dreq_s1, dreq_s2, rdy_s1, rdy_s2, rdy_prev, pos_s1, pos_s2;
  logic [DATA_W-1:0] din_s1, din_s2;
  logic burst, next_burst, burst_wr, next_burst_wr;
  logic next_dack_n, next_rd_n, next_wr_n, next_cs1_n, next_cs3_n, next_doe;
  logic [ADDR_W-1:0] next_reg_addr;
  logic [DATA_W-1:0] next_dout, next_result;
  logic next_done_tgl;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_op = op;
    next_req_seen = req_seen;
    next_burst = burst;
    next_burst_wr = burst_wr;
    next_dack_n = pri_dma_ack_n;
    next_rd_n = pri_read_cmd_n;
    next_wr_n = pri_write_cmd_n;
    next_cs1_n = pri_cmd_block_sel_n;
    next_cs3_n = pri_ctl_block_sel_n;
    next_reg_addr = pri_reg_addr;
    next_doe = pri_data_oe;
    next_dout = pri_data_out;
    next_result = result_data;
    next_done_tgl = done_tgl;
    case (state)
      S_IDLE:
      begin
        if ((req_s2 != req_seen) && !pos_s2)
        begin
          next_req_seen = req_s2;
          next_op = pay_op;
          next_dout = pay_wdata;
          if (pay_op == OP_UD_STOP)
          begin
            next_state = burst ? S_UD_STOP : S_DONE;
            next_wr_n = !burst;
            next_cnt = STOP_CYC;
          end
          else if (is_udma(pay_op) && burst)
          begin
            next_state = is_write(pay_op) ? S_UD_WR : S_UD_RD;
            next_rd_n = is_write(pay_op) ? pri_read_cmd_n : 1'b0;
            next_doe = is_write(pay_op);
            next_cnt = SETUP_CYC;
          end
          else if (is_dma(pay_op))
          begin
            next_state = S_DMA_WAIT;
          end
          else if (pay_op == OP_REG_RD || pay_op == OP_REG_WR)
          begin
            next_cs1_n = pay_ctl;
            next_cs3_n = !pay_ctl;
            next_reg_addr = pay_addr;
            next_doe = is_write(pay_op);
            next_cnt = SETUP_CYC;
            next_state = S_SETUP;
          end
          else
          begin
            next_state = S_DONE;
          end
        end
      end
      S_DMA_WAIT:
      begin
        if (dreq_s2)
        begin
          next_dack_n = 1'b0;
          next_cnt = SETUP_CYC;
          if (is_udma(op))
          begin
            next_burst = 1'b1;
            next_burst_wr = is_write(op);
            next_state = is_write(op) ? S_UD_WR : S_UD_RD;
            next_rd_n = is_write(op);
            next_doe = is_write(op);
          end
          else
          begin
            next_doe = is_write(op);
            next_state = S_SETUP;
          end
        end
      end
      S_SETUP:
      begin
        next_cnt = cnt - 4'h1;
        if (cnt <= 4'h1)
        begin
          next_rd_n = is_write(op);
          next_wr_n = !is_write(op);
          next_cnt = STROBE_CYC;
          next_state = S_STROBE;
        end
      end
      S_STROBE:
      begin
        if (cnt > 4'h1)
        begin
          next_cnt = cnt - 4'h1;
        end
        else if (rdy_s2 || is_dma(op))
        begin
          next_rd_n = 1'b1;
          next_wr_n = 1'b1;
          if (!is_write(op))
          begin
            next_result = din_s2;
          end
          next_cnt = RECOVER_CYC;
          next_state = S_RECOVER;
        end
      end
      S_RECOVER:
      begin
        next_cnt = cnt - 4'h1;
        if (cnt <= 4'h1)
        begin
          next_state = S_DONE;
          if (!burst)
          begin
            next_doe = 1'b0;
            next_cs1_n = 1'b1;
            next_cs3_n = 1'b1;
            next_dack_n = 1'b1;
          end
        end
      end
      S_UD_RD:
      begin
        if (rdy_s2 != rdy_prev)
        begin
          next_result = din_s2;
          next_rd_n = 1'b1;
          next_state = S_DONE;
        end
      end
      S_UD_WR:
      begin
        if (cnt > 4'h1)
        begin
          next_cnt = cnt - 4'h1;
        end
        else if (!rdy_s2)
        begin
          next_rd_n = !pri_read_cmd_n;
          next_cnt = RECOVER_CYC;
          next_state = S_RECOVER;
        end
      end
      S_UD_STOP:
      begin
        next_cnt = cnt - 4'h1;
        if (cnt <= 4'h1)
        begin
          next_wr_n = 1'b1;
          next_rd_n = 1'b1;
          next_dack_n = 1'b1;
          next_doe = 1'b0;
          next_burst = 1'b0;
          next_burst_wr = 1'b0;
          next_state = S_DONE;
        end
      end
      S_DONE:
      begin
        next_done_tgl = !done_tgl;
        next_state = S_IDLE;
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
    // suspend parks the strobes, selects, acknowledge and data enable and ends any transfer
    if (pos_s2)
    begin
      next_dack_n = 1'b1;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      next_cs1_n = 1'b1;
      next_cs3_n = 1'b1;
      next_doe = 1'b0;
      next_burst = 1'b0;
      next_burst_wr = 1'b0;
      if (state != S_IDLE && state != S_DONE)
      begin
        next_state = S_DONE;
      end
    end
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= S_IDLE;
      cnt <= 4'h0;
      op <= OP_REG_RD;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_seen <= 1'b0;
      dreq_s1 <= 1'b0;
      dreq_s2 <= 1'b0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_prev <= 1'b0;
      pos_s1 <= 1'b0;
      pos_s2 <= 1'b0;
      din_s1 <= '0;
      din_s2 <= '0;
      burst <= 1'b0;
      burst_wr <= 1'b0;
      pri_dma_ack_n <= PIN_NEGATED;
      pri_read_cmd_n <= PIN_NEGATED;
      pri_write_cmd_n <= PIN_NEGATED;
      pri_write_cmd_oe <= 1'b1;
      pri_cmd_block_sel_n <= PIN_NEGATED;
      pri_ctl_block_sel_n <= PIN_NEGATED;
      pri_reg_addr <= REG_ADDR_RST;
      pri_data_oe <= 1'b0;
      pri_data_out <= '0;
      result_data <= '0;
      done_tgl <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_seen <= next_req_seen;
      dreq_s1 <= pri_dma_req;
      dreq_s2 <= dreq_s1;
      rdy_s1 <= pri_channel_ready;
      rdy_s2 <= rdy_s1;
      rdy_prev <= rdy_s2;
      pos_s1 <= power_on_suspend;
      pos_s2 <= pos_s1;
      din_s1 <= pri_data_in;
      din_s2 <= din_s1;
      burst <= next_burst;
      burst_wr <= next_burst_wr;
      pri_dma_ack_n <= next_dack_n;
      pri_read_cmd_n <= next_rd_n;
      pri_write_cmd_n <= next_wr_n;
      pri_write_cmd_oe <= !pos_s2;
      pri_cmd_block_sel_n <= next_cs1_n;
      pri_ctl_block_sel_n <= next_cs3_n;
      pri_reg_addr <= next_reg_addr;
      pri_data_oe <= next_doe;
      pri_data_out <= next_dout;
      result_data <= next_result;
      done_tgl <= next_done_tgl;
    end
  end

  sequence s_stop_begin;
    $fell(pri_write_cmd_n) && burst;
  endsequence

  sequence s_burst_closed;
    pri_dma_ack_n && pri_write_cmd_n;
  endsequence

  property p_dack_idle;
    @(posedge link_clk) disable iff (!arst_n) (state == S_IDLE && !burst) |-> pri_dma_ack_n;
  endproperty
  a_dack_idle: assert property (p_dack_idle) else $error("ack asserted while idle");

  property p_pos_park;
    @(posedge link_clk) disable iff (!arst_n) pos_s2 |=> (pri_dma_ack_n && pri_read_cmd_n);
  endproperty
  a_pos_park: assert property (p_pos_park) else $error("ack or read low in suspend");

  property p_pos_wr_float;
    @(posedge link_clk) disable iff (!arst_n) pos_s2 |=> !pri_write_cmd_oe;
  endproperty
  a_pos_wr_float: assert property (p_pos_wr_float) else $error("write strobe driven in suspend");

  property p_wr_driven;
    @(posedge link_clk) disable iff (!arst_n) !pos_s2 |=> pri_write_cmd_oe;
  endproperty
  a_wr_driven: assert property (p_wr_driven) else $error("write strobe released outside suspend");

  property p_dack_after_req;
    @(posedge link_clk) disable iff (!arst_n) $fell(pri_dma_ack_n) |-> $past(dreq_s2);
  endproperty
  a_dack_after_req: assert property (p_dack_after_req) else $error("ack without request");

  property p_reg_no_dack;
    @(posedge link_clk) disable iff (!arst_n)
      (state == S_STROBE && !is_dma(op)) |-> (pri_dma_ack_n && !(pri_cmd_block_sel_n && pri_ctl_block_sel_n));
  endproperty
  a_reg_no_dack: assert property (p_reg_no_dack) else $error("register cycle target wrong");

  property p_read_capture;
    @(posedge link_clk) disable iff (!arst_n)
      (state == S_STROBE && next_state == S_RECOVER && !is_write(op)) |=> (result_data == $past(din_s2));
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read data not captured");

  property p_ud_rd_pause;
    @(posedge link_clk) disable iff (!arst_n) (burst && !burst_wr && state == S_IDLE) |-> pri_read_cmd_n;
  endproperty
  a_ud_rd_pause: assert property (p_ud_rd_pause) else $error("ready held with no word wanted");

  property p_ud_wr_toggle;
    @(posedge link_clk) disable iff (!arst_n)
      (burst_wr && $past(burst_wr) && $changed(pri_read_cmd_n) && !$past(pos_s2)) |-> !$past(rdy_s2);
  endproperty
  a_ud_wr_toggle: assert property (p_ud_wr_toggle) else $error("strobe toggled while paused");

  property p_stop_ends;
    @(posedge link_clk) disable iff (!arst_n) s_stop_begin |-> ##[1:8] s_burst_closed;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop did not end the burst");

endmodule : apch_channel
`default_nettype wire

//--- hw/apch_pkg.sv
// apch_pkg: constants, command codes and state type for the primary ATA channel
// assumes the pin-side logic runs on the link clock whose period is LINK_PERIOD_NS
package apch_pkg;

  // link clock period used to turn strobe times into cycle counts
  localparam int unsigned LINK_PERIOD_NS = 125;
  localparam int unsigned T_SETUP_NS = 70;
  localparam int unsigned T_STROBE_NS = 165;
  localparam int unsigned T_RECOVER_NS = 125;
  localparam int unsigned T_STOP_NS = 250;

  // least times round up, never below one cycle
  function automatic logic [3:0] ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[3:0];
  endfunction : ns_to_cyc

  localparam logic [3:0] SETUP_CYC = ns_to_cyc(T_SETUP_NS);
  localparam logic [3:0] STROBE_CYC = ns_to_cyc(T_STROBE_NS);
  localparam logic [3:0] RECOVER_CYC = ns_to_cyc(T_RECOVER_NS);
  localparam logic [3:0] STOP_CYC = ns_to_cyc(T_STOP_NS);

  // command codes; bit 0 marks a write for every data command
  localparam logic [2:0] OP_REG_RD = 3'h0;
  localparam logic [2:0] OP_REG_WR = 3'h1;
  localparam logic [2:0] OP_DMA_RD = 3'h2;
  localparam logic [2:0] OP_DMA_WR = 3'h3;
  localparam logic [2:0] OP_UD_RD = 3'h4;
  localparam logic [2:0] OP_UD_WR = 3'h5;
  localparam logic [2:0] OP_UD_STOP = 3'h6;

  // reset levels of the pins
  localparam logic PIN_NEGATED = 1'h1;
  localparam logic [2:0] REG_ADDR_RST = 3'h0;

  typedef enum logic [8:0] {
    S_IDLE     = 9'h001,
    S_DMA_WAIT = 9'h002,
    S_SETUP    = 9'h004,
    S_STROBE   = 9'h008,
    S_RECOVER  = 9'h010,
    S_UD_RD    = 9'h020,
    S_UD_WR    = 9'h040,
    S_UD_STOP  = 9'h080,
    S_DONE     = 9'h100
  } apch_state_e;

endpackage : apch_pkg

//--- testbench/apch_drive_model.sv
// apch_drive_model: behavioural drive on the primary connector
// assumes the bench resolves the floating write strobe and the data bus
`timescale 1ns/1ps
`default_nettype none
module apch_drive_model (
  // bench control
  input wire logic link_clk,
  input wire logic req_en,
  input wire logic udma,
  input wire logic rd_dir,
  input wire logic pause,
  input wire logic [15:0] rd_word,
  // pins
  output logic pri_dma_req,
  input wire logic pri_dma_ack_n,
  input wire logic pri_read_cmd_n,
  input wire logic write_w,
  output logic pri_channel_ready,
  input wire logic pri_cmd_block_sel_n,
  input wire logic pri_ctl_block_sel_n,
  input wire logic [2:0] pri_reg_addr,
  input wire logic [15:0] data_w,
  input wire logic host_drives,
  output logic [15:0] pri_data_in,
  // what the drive saw
  output logic [2:0] last_sel,
  output logic [2:0] last_addr,
  output logic [15:0] last_data,
  output logic [15:0] ud_data,
  output int n_cap
);
  logic strobe = 1'b1;
  int gap = 0;
  int cnt = 0;
  logic sel;
  assign n_cap = cnt;
  assign sel = !pri_cmd_block_sel_n || !pri_ctl_block_sel_n || !pri_dma_ack_n;
  assign pri_dma_req = req_en;
  // off the bus the lines show the inverse word
  assign pri_data_in = (sel && !host_drives) ? rd_word : ~rd_word;
  always_comb
  begin
    if (udma && rd_dir)
      pri_channel_ready = strobe;
    else if (udma)
      pri_channel_ready = pause;
    else
      pri_channel_ready = !pause;
  end
  // one strobe edge per ready window, spaced so the host can pause
  always @(posedge link_clk)
  begin
    if (gap != 0)
      gap <= gap - 1;
    else if (udma && rd_dir && !pri_dma_ack_n && !pri_read_cmd_n)
    begin
      strobe <= ~strobe;
      gap <= 6;
    end
  end
  // normal cycles end at the strobe negation
  always @(posedge write_w or posedge pri_read_cmd_n)
  begin
    if (!udma)
    begin
      last_sel <= {pri_dma_ack_n, pri_ctl_block_sel_n, pri_cmd_block_sel_n};
      last_addr <= pri_reg_addr;
      last_data <= data_w;
    end
  end
  // burst write words on both strobe edges
  always @(pri_read_cmd_n)
  begin
    if (udma && !rd_dir && !pri_dma_ack_n)
    begin
      ud_data <= data_w;
      cnt <= cnt + 1;
    end
  end
endmodule : apch_drive_model
`default_nettype wire

//--- testbench/test_ata_primary_channel_host_signalling.sv
// test bench: table of register and DMA cycles, then hand tests
// assumes apch_drive_model on the pins and the package constants
`timescale 1ns/1ps
`default_nettype none
module test_ata_primary_channel_host_signalling
  import apch_pkg::*;
;
  typedef struct {
    logic [2:0] op;
    logic ctl;
    logic [2:0] addr;
    logic [15:0] word;
    logic [2:0] sel;
  } apch_row_s;
  apch_row_s rows [6] = '{
    '{OP_REG_RD, 1'b0, 3'h7, 16'hA55A, 3'h6},
    '{OP_REG_WR, 1'b1, 3'h6, 16'h1234, 3'h5},
    '{OP_REG_WR, 1'b0, 3'h0, 16'hFFFF, 3'h6},
    '{OP_REG_RD, 1'b1, 3'h2, 16'h0001, 3'h5},
    '{OP_DMA_RD, 1'b0, 3'h0, 16'h8000, 3'h3},
    '{OP_DMA_WR, 1'b0, 3'h0, 16'h7FFE, 3'h3}};
  logic clk, link_clk, arst_n, sus, strap, cmd_valid, cmd_ctl;
  logic [2:0] cmd_op, cmd_addr, pin_addr, last_sel, last_addr;
  logic [15:0] cmd_wdata, rd_word, rsp_rdata, d_in, d_out, last_data, ud_data;
  logic req_en, udma, rd_dir, pause, cmd_ready, rsp_valid, cfg_pm_ps, req, rdy;
  logic ack_n, rd_n, wr_n, wr_oe, sel_cmd_n, sel_ctl_n, d_oe, write_w;
  int n_cap, base, n_fail = 0, total_checks = 0;
  assign write_w = wr_oe ? wr_n : 1'b0;
  apch_channel uut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk),
    .power_on_suspend(sus), .arrange_pm_ps(strap), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_ctl_block(cmd_ctl), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .cfg_pm_ps(cfg_pm_ps), .pri_dma_req(req), .pri_dma_ack_n(ack_n),
    .pri_read_cmd_n(rd_n), .pri_write_cmd_n(wr_n), .pri_write_cmd_oe(wr_oe),
    .pri_channel_ready(rdy), .pri_cmd_block_sel_n(sel_cmd_n),
    .pri_ctl_block_sel_n(sel_ctl_n), .pri_reg_addr(pin_addr), .pri_data_in(d_in),
    .pri_data_out(d_out), .pri_data_oe(d_oe));
  apch_drive_model u_drive (.link_clk(link_clk), .req_en(req_en), .udma(udma),
    .rd_dir(rd_dir), .pause(pause), .rd_word(rd_word), .pri_dma_req(req),
    .pri_dma_ack_n(ack_n), .pri_read_cmd_n(rd_n), .write_w(write_w),
    .pri_channel_ready(rdy), .pri_cmd_block_sel_n(sel_cmd_n),
    .pri_ctl_block_sel_n(sel_ctl_n), .pri_reg_addr(pin_addr), .data_w(d_out),
    .host_drives(d_oe), .pri_data_in(d_in), .last_sel(last_sel),
    .last_addr(last_addr), .last_data(last_data), .ud_data(ud_data), .n_cap(n_cap));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic lwait(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask : lwait
  task automatic send(input logic [2:0] op, input logic [15:0] w);
    int i;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_wdata = w;
    while (cmd_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    for (i = 0; i < 4000 && rsp_valid !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    check(rsp_valid, 1'b1);
  endtask : send
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    check({ack_n, rd_n, wr_n, wr_oe, sel_cmd_n, sel_ctl_n}, 6'h3F);
    arst_n = 1'b1;
    lwait(3);
    check({ack_n, rd_n, wr_n, wr_oe, sel_cmd_n, sel_ctl_n}, 6'h3F);
    $display("test reset done");
  endtask : do_reset
  task automatic stop_burst;
    int i;
    fork
      send(OP_UD_STOP, 16'h0000);
      begin
        for (i = 0; i < 40 && wr_n !== 1'b0; i++)
          lwait(1);
        check(wr_n, 1'b0);
      end
    join
    check(ack_n, 1'b1);
  endtask : stop_burst
  initial
  begin
    #500000;
    n_fail++;
    print_verdict();
  end
  initial
  begin
    {sus, strap, cmd_valid, cmd_ctl, cmd_op, cmd_addr, cmd_wdata} = '0;
    {req_en, udma, rd_dir, pause} = 4'h8;
    rd_word = 16'h0000;
    do_reset();
    // both arrangements run the same table
    for (int s = 0; s < 2; s++)
    begin
      strap = s[0];
      foreach (rows[k])
      begin
        cmd_ctl = rows[k].ctl;
        cmd_addr = rows[k].addr;
        rd_word = rows[k].word;
        send(rows[k].op, rows[k].word);
        check(last_sel, rows[k].sel);
        if (rows[k].sel[2])
          check(last_addr, rows[k].addr);
        if (rows[k].op[0])
          check(last_data, rows[k].word);
        else
          check(rsp_rdata, rows[k].word);
        check(ack_n, 1'b1);
      end
      check(cfg_pm_ps, strap);
      $display("test table done");
    end
    // drive not ready stretches the read strobe
    pause = 1'b1;
    fork
      send(OP_REG_RD, 16'h0000);
      begin
        lwait(20);
        check(rd_n, 1'b0);
        pause = 1'b0;
      end
    join
    // no acknowledge before the drive requests
    req_en = 1'b0;
    rd_word = 16'hC3C3;
    fork
      send(OP_DMA_RD, 16'h0000);
      begin
        lwait(20);
        check(ack_n, 1'b1);
        req_en = 1'b1;
      end
    join
    check(rsp_rdata, 16'hC3C3);
    $display("test waits done");
    udma = 1'b1;
    rd_dir = 1'b1;
    for (int w = 0; w < 2; w++)
    begin
      rd_word = 16'h3C00 + 16'(w);
      send(OP_UD_RD, 16'h0000);
      check(rsp_rdata, 16'h3C00 + 16'(w));
      check(rd_n, 1'b1);
    end
    stop_burst();
    rd_dir = 1'b0;
    pause = 1'b1;
    base = n_cap;
    fork
      send(OP_UD_WR, 16'h5AA5);
      begin
        lwait(20);
        check(16'(n_cap - base), 16'h0000);
        pause = 1'b0;
      end
    join
    send(OP_UD_WR, 16'h0FF0);
    check(16'(n_cap - base), 16'h0002);
    check(ud_data, 16'h0FF0);
    stop_burst();
    udma = 1'b0;
    $display("test burst done");
    // register read after a write burst, then stop with no burst and the spare code
    rd_word = 16'h9669;
    send(OP_REG_RD, 16'h0000);
    check(rsp_rdata, 16'h9669);
    send(OP_UD_STOP, 16'h0000);
    check(wr_n, 1'b1);
    send(3'h7, 16'h0000);
    check(rsp_rdata, 16'h9669);
    check(ack_n, 1'b1);
    $display("test idle codes done");
    // suspend aborts a DMA cycle that waits for its request
    req_en = 1'b0;
    fork
      send(OP_DMA_RD, 16'h0000);
      begin
        lwait(10);
        sus = 1'b1;
      end
    join
    lwait(6);
    check(wr_oe, 1'b0);
    check({ack_n, rd_n}, 2'h3);
    check(rsp_rdata, 16'h9669);
    sus = 1'b0;
    req_en = 1'b1;
    lwait(6);
    check(wr_oe, 1'b1);
    $display("test suspend done");
    do_reset();
    print_verdict();
  end
endmodule : test_ata_primary_channel_host_signalling
`default_nettype wire
